// ===== logic/tmc_mode_ctrl.sv
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// operating mode controller
// ************************************************************
module tmc_mode_ctrl #(
  parameter int SEC_LEN = tmc_pkg::SEC_CYCLES,
  parameter int BLINK_LEN = tmc_pkg::BLINK_CYCLES,
  parameter int TONE_LEN = tmc_pkg::TONE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic charger_pin,
  input wire logic battery_full_pin,
  input wire logic motion_pin,
  input wire logic nfc_access_pin,
  input wire logic nfc_release_pin,
  input wire logic batt_low,
  input wire logic batt_critical,
  input wire logic start_alert,
  input wire logic end_alert,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic meas_request,
  output logic [2:0] led_colour,
  output logic led_on,
  output logic buzzer,
  output logic vibrator,
  output logic scan_en,
  output logic discovery_en,
  output logic ranging_en,
  output logic subghz_en,
  output logic uwb_en,
  output logic ble_nfc_en,
  output logic [1:0] report_mode,
  output logic log_en
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic charger;
  logic bat_full;
  logic motion;
  logic nfc_acc;
  logic nfc_rel;
  tmc_sync u_sync_chg (.sys_clk(sys_clk), .rst(rst), .din(charger_pin), .dout(charger));
  tmc_sync u_sync_full (.sys_clk(sys_clk), .rst(rst), .din(battery_full_pin), .dout(bat_full));
  tmc_sync u_sync_mot (.sys_clk(sys_clk), .rst(rst), .din(motion_pin), .dout(motion));
  tmc_sync u_sync_nfc (.sys_clk(sys_clk), .rst(rst), .din(nfc_access_pin), .dout(nfc_acc));
  tmc_sync u_sync_rel (.sys_clk(sys_clk), .rst(rst), .din(nfc_release_pin), .dout(nfc_rel));

  // ************************************************************
  // register file
  // ************************************************************
  logic [31:0] ctrl;
  logic [31:0] motionless_s;
  logic [31:0] meas_s;
  logic [31:0] alert_to_s;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_held;
  logic w_held;
  logic do_write;
  logic mode_write;
  tmc_pkg::tmc_state_t state;
  tmc_pkg::tmc_state_t next_state;
  logic alerting;
  logic low_flag;

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign mode_write = do_write && (awaddr_q[7:0] == tmc_pkg::ADDR_CTRL) && wstrb_q[0];

  // address and data channels are taken independently
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // ready registered; low while a word is held
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // byte-lane write into the selected register
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // writes; an unmapped address answers slverr
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= tmc_pkg::CTRL_RESET;
      motionless_s <= tmc_pkg::MOTIONLESS_RESET;
      meas_s <= tmc_pkg::MEAS_RESET;
      alert_to_s <= tmc_pkg::ALERT_TO_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        unique case (awaddr_q[7:0])
          tmc_pkg::ADDR_CTRL: ctrl <= lane_merge(ctrl, wdata_q, wstrb_q);
          tmc_pkg::ADDR_MOTIONLESS: motionless_s <= lane_merge(motionless_s, wdata_q, wstrb_q);
          tmc_pkg::ADDR_MEAS: meas_s <= lane_merge(meas_s, wdata_q, wstrb_q);
          tmc_pkg::ADDR_ALERT_TO: alert_to_s <= lane_merge(alert_to_s, wdata_q, wstrb_q);
          tmc_pkg::ADDR_STATUS: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
    end
  end

  // reads answer one cycle after the address is taken
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        unique case (s_axi_araddr[7:0])
          tmc_pkg::ADDR_CTRL: s_axi_rdata <= {25'h0, ctrl[6:0]};
          tmc_pkg::ADDR_MOTIONLESS: s_axi_rdata <= motionless_s;
          tmc_pkg::ADDR_MEAS: s_axi_rdata <= meas_s;
          tmc_pkg::ADDR_ALERT_TO: s_axi_rdata <= alert_to_s;
          tmc_pkg::ADDR_STATUS: s_axi_rdata <= {24'h0, low_flag, alerting, charger, 5'(state)};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // timers
  // ************************************************************
  logic still_expired;
  logic meas_tick;
  logic alert_expired;
  logic meas_restart;

  // motionless timer restarts on any motion
  tmc_sec_timer #(.SEC_LEN(SEC_LEN)) u_still (.sys_clk(sys_clk), .rst(rst), .restart(motion),
    .limit(motionless_s), .expired(still_expired));

  // measurement tick re-arms itself on each expiry
  assign meas_restart = meas_tick;
  tmc_sec_timer #(.SEC_LEN(SEC_LEN)) u_meas (.sys_clk(sys_clk), .rst(rst), .restart(meas_restart),
    .limit(meas_s), .expired(meas_tick));

  tmc_sec_timer #(.SEC_LEN(SEC_LEN)) u_alert (.sys_clk(sys_clk), .rst(rst), .restart(!alerting),
    .limit(alert_to_s), .expired(alert_expired));

  // ************************************************************
  // mode state machine
  // ************************************************************
  logic crit_latched;
  logic [1:0] mode_set;
  localparam int CTRL_MODE_MSB_IDX = tmc_pkg::CTRL_MODE_LSB + 1;
  assign mode_set = ctrl[CTRL_MODE_MSB_IDX:tmc_pkg::CTRL_MODE_LSB];

  // critical level sampled at each measurement, cleared only above it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      crit_latched <= 1'b0;
      low_flag <= 1'b0;
      meas_request <= 1'b0;
    end else begin
      meas_request <= meas_tick;
      if (meas_tick) begin
        crit_latched <= batt_critical;
        low_flag <= batt_low;
      end
    end
  end

  // priority: charger, critical, nfc, mode setting, autosleep
  always_comb begin
    next_state = state;
    if (charger) begin
      next_state = tmc_pkg::ST_CHARGING;
    end else if (crit_latched) begin
      next_state = tmc_pkg::ST_DEEPSLEEP;
    end else begin
      unique case (state)
        tmc_pkg::ST_DEEPSLEEP: next_state = tmc_pkg::ST_DEEPSLEEP;
        tmc_pkg::ST_CHARGING: next_state = tmc_pkg::ST_MONITOR;
        tmc_pkg::ST_NFC: begin
          if (nfc_rel) begin
            next_state = tmc_pkg::ST_MONITOR;
          end
        end
        tmc_pkg::ST_SLEEP: begin
          if (mode_set == tmc_pkg::MODE_SHELF) begin
            next_state = tmc_pkg::ST_DEEPSLEEP;
          end else if (mode_set == tmc_pkg::MODE_TAG && motion) begin
            next_state = tmc_pkg::ST_MONITOR;
          end
        end
        tmc_pkg::ST_MONITOR: begin
          if (nfc_acc) begin
            next_state = tmc_pkg::ST_NFC;
          end else if (mode_set == tmc_pkg::MODE_SHELF) begin
            next_state = tmc_pkg::ST_DEEPSLEEP;
          end else if (mode_set == tmc_pkg::MODE_MAINT) begin
            next_state = tmc_pkg::ST_SLEEP;
          end else if (ctrl[tmc_pkg::CTRL_AUTOSLEEP] && still_expired) begin
            next_state = tmc_pkg::ST_SLEEP;
          end
        end
        default: next_state = tmc_pkg::ST_DEEPSLEEP;
      endcase
    end
  end

  // state register; leaving charging enters monitoring with ctrl left unchanged
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= tmc_pkg::ST_DEEPSLEEP;
    end else begin
      state <= next_state;
    end
  end

  // active means monitoring, or charging with keep-running
  logic active;
  assign active = (state == tmc_pkg::ST_MONITOR)
    || (state == tmc_pkg::ST_CHARGING && ctrl[tmc_pkg::CTRL_KEEP_RUN]);

  // ************************************************************
  // alert pattern
  // ************************************************************
  // alert events come from the ranging logic, never from the uplink
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alerting <= 1'b0;
    end else if (!active) begin
      alerting <= 1'b0;
    end else if (start_alert) begin
      alerting <= 1'b1;
    end else if (end_alert || alert_expired) begin
      alerting <= 1'b0;
    end
  end

  // blink and tone generators
  logic [31:0] blink_cnt;
  logic blink_phase;
  logic [15:0] tone_cnt;
  logic tone_sel;
  logic tone_wave;
  logic low_blink;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      blink_cnt <= 32'h0;
      blink_phase <= 1'b0;
      tone_sel <= 1'b0;
    end else if (blink_cnt == 32'(BLINK_LEN - 1)) begin
      blink_cnt <= 32'h0;
      blink_phase <= !blink_phase;
      tone_sel <= blink_phase ? !tone_sel : tone_sel;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // two tones: one period, then twice that
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tone_cnt <= 16'h0;
      tone_wave <= 1'b0;
    end else if (tone_cnt >= (tone_sel ? 16'(2 * TONE_LEN) : 16'(TONE_LEN))) begin
      tone_cnt <= 16'h0;
      tone_wave <= !tone_wave;
    end else begin
      tone_cnt <= tone_cnt + 16'h1;
    end
  end

  // one orange blink after each low measurement, mode unchanged
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_blink <= 1'b0;
    end else if (meas_tick && batt_low) begin
      low_blink <= 1'b1;
    end else if (blink_cnt == 32'(BLINK_LEN - 1) && blink_phase) begin
      low_blink <= 1'b0;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      led_colour <= tmc_pkg::LED_OFF;
      led_on <= 1'b0;
      buzzer <= 1'b0;
      vibrator <= 1'b0;
    end else begin
      buzzer <= alerting && active && tone_wave;
      vibrator <= alerting && active && blink_phase;
      if (state == tmc_pkg::ST_CHARGING) begin
        led_colour <= bat_full ? tmc_pkg::LED_GREEN : tmc_pkg::LED_ORANGE;
        led_on <= blink_phase;
      end else if (state == tmc_pkg::ST_NFC) begin
        led_colour <= tmc_pkg::LED_BLUE;
        led_on <= blink_phase;
      end else if (alerting) begin
        led_colour <= tmc_pkg::LED_RED;
        led_on <= blink_phase;
      end else if (low_blink) begin
        led_colour <= tmc_pkg::LED_ORANGE;
        led_on <= blink_phase;
      end else begin
        led_colour <= tmc_pkg::LED_OFF;
        led_on <= 1'b0;
      end
    end
  end

  // radio enables; deepsleep keeps every radio off, report_mode and log_en follow ctrl
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scan_en <= 1'b0;
      discovery_en <= 1'b0;
      ranging_en <= 1'b0;
      subghz_en <= 1'b0;
      uwb_en <= 1'b0;
      ble_nfc_en <= 1'b0;
      report_mode <= 2'h0;
      log_en <= 1'b0;
    end else begin
      scan_en <= active;
      discovery_en <= active && !ctrl[tmc_pkg::CTRL_PASSIVE];
      ranging_en <= active;
      uwb_en <= active;
      subghz_en <= active || state == tmc_pkg::ST_SLEEP || state == tmc_pkg::ST_CHARGING;
      ble_nfc_en <= state != tmc_pkg::ST_DEEPSLEEP;
      report_mode <= ctrl[tmc_pkg::CTRL_REPORT_LSB +: 2];
      log_en <= ctrl[tmc_pkg::CTRL_REPORT_LSB +: 2] != tmc_pkg::REP_NONE;
    end
  end
endmodule
`default_nettype wire

// ===== logic/tmc_pkg.sv
// Overview of operation
// - reset starts in deepsleep, radios off
// - deepsleep means no scan, ranging, emission
// - charger detected forces charging, orange blink
// - full battery in charging turns blink green
// - stay charging while plugged; unplug means monitoring
// - low battery gives one orange blink per measurement
// - critical battery forces deepsleep until charged above
// - autosleep after motionless timeout; motion resumes monitoring
// - otherwise monitoring with scanning and ranging
// - start alert: red blink, vibrator, two-tone buzzer
// - alert ends on end event or timeout
// - nfc access leaves monitoring, radios off except ble/nfc, blue blink
// - mode setting is shelf, maintenance or tag
// - keep-running option keeps monitoring while plugged
// - passive option stops discovery, answers still given
// - reporting mode selects one of four behaviours
// - alerts never depend on gateway connectivity
// - alert starts inside distance, ends past hysteresis
package tmc_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MOTIONLESS = 8'h04;
  localparam logic [7:0] ADDR_MEAS = 8'h08;
  localparam logic [7:0] ADDR_ALERT_TO = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_KEEP_RUN = 2;
  localparam int CTRL_PASSIVE = 3;
  localparam int CTRL_AUTOSLEEP = 4;
  localparam int CTRL_REPORT_LSB = 5;

  // mode setting encodings
  localparam logic [1:0] MODE_SHELF = 2'h0;
  localparam logic [1:0] MODE_MAINT = 2'h1;
  localparam logic [1:0] MODE_TAG = 2'h2;

  // reporting mode encodings
  localparam logic [1:0] REP_IMMEDIATE = 2'h0;
  localparam logic [1:0] REP_RELAY = 2'h1;
  localparam logic [1:0] REP_LOG_ONLY = 2'h2;
  localparam logic [1:0] REP_NONE = 2'h3;

  // reset values: tag mode, autosleep on, immediate reporting
  localparam logic [31:0] CTRL_RESET = 32'h0000_0012;
  localparam logic [31:0] MOTIONLESS_RESET = 32'h0000_0258;
  localparam logic [31:0] MEAS_RESET = 32'h0000_003c;
  localparam logic [31:0] ALERT_TO_RESET = 32'h0000_001e;

  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1000);
  localparam int TONE_CYCLES = 25_000;

  // led colours
  localparam logic [2:0] LED_OFF = 3'h0;
  localparam logic [2:0] LED_ORANGE = 3'h1;
  localparam logic [2:0] LED_GREEN = 3'h2;
  localparam logic [2:0] LED_RED = 3'h3;
  localparam logic [2:0] LED_BLUE = 3'h4;

  // operating states, one-hot
  typedef enum logic [4:0] {
    ST_DEEPSLEEP = 5'h01,
    ST_CHARGING = 5'h02,
    ST_SLEEP = 5'h04,
    ST_MONITOR = 5'h08,
    ST_NFC = 5'h10
  } tmc_state_t;

endpackage

// ===== logic/tmc_sec_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// seconds timer: counts whole seconds while running
// ************************************************************
module tmc_sec_timer #(
  parameter int SEC_LEN = 50_000_000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic [31:0] limit,
  output logic expired
);
  logic [31:0] frac;
  logic [31:0] secs;

  // prescaler and second counter; restart re-arms both
  always_ff @(posedge sys_clk) begin
    if (rst || restart) begin
      frac <= 32'h0;
      secs <= 32'h0;
    end else if (frac == 32'(SEC_LEN - 1)) begin
      frac <= 32'h0;
      if (secs != 32'hffff_ffff) begin
        secs <= secs + 32'h1;
      end
    end else begin
      frac <= frac + 32'h1;
    end
  end

  // a zero limit never expires rather than firing at once
  always_ff @(posedge sys_clk) begin
    if (rst || restart) begin
      expired <= 1'b0;
    end else begin
      expired <= (limit != 32'h0) && (secs >= limit);
    end
  end
endmodule
`default_nettype wire

// ===== logic/tmc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// two-stage synchroniser for pin inputs
// ************************************************************
module tmc_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic meta;

  // first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tmc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// port checker for the mode controller
// ************************************************************
module tmc_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic charger_pin,
  input wire logic start_alert,
  input wire logic end_alert,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic meas_request,
  input wire logic [2:0] led_colour,
  input wire logic buzzer,
  input wire logic vibrator,
  input wire logic scan_en,
  input wire logic discovery_en,
  input wire logic ranging_en,
  input wire logic subghz_en,
  input wire logic uwb_en,
  input wire logic ble_nfc_en
);
  // one clock domain, so clocking and reset are declared once
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_reset_quiet;
    $fell(rst) |-> !(scan_en || ranging_en || subghz_en || uwb_en || ble_nfc_en || buzzer);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("radio or alert active right after reset");

  property p_nfc_radio;
    led_colour == tmc_pkg::LED_BLUE |-> !subghz_en && !uwb_en;
  endproperty
  a_nfc_radio: assert property (p_nfc_radio)
    else $error("long range radios on during blue blink");

  property p_alert_red;
    vibrator |-> led_colour == tmc_pkg::LED_RED;
  endproperty
  a_alert_red: assert property (p_alert_red)
    else $error("vibrator pulses without red led");

  // three quiet cycles cover the registered path from the event
  property p_alert_end;
    end_alert ##1 (!start_alert)[*3] |-> !vibrator && !buzzer;
  endproperty
  a_alert_end: assert property (p_alert_end)
    else $error("alert pattern outlives end event");

  property p_meas_gap;
    meas_request |=> (!meas_request)[*8];
  endproperty
  a_meas_gap: assert property (p_meas_gap)
    else $error("measurement requests too close");

  property p_read_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_ans: assert property (p_read_ans)
    else $error("read answer late");

  // eight cycles cover synchroniser plus state and output registers
  property p_charge_led;
    charger_pin[*8] |-> led_colour inside {tmc_pkg::LED_ORANGE, tmc_pkg::LED_GREEN};
  endproperty
  a_charge_led: assert property (p_charge_led)
    else $error("charger present without charge colour");

  property p_disc_scan;
    discovery_en |-> scan_en;
  endproperty
  a_disc_scan: assert property (p_disc_scan)
    else $error("discovery without scanning");
endmodule
`default_nettype wire

// ===== testbench/tmc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// charger, motion sensor, cell and neighbour tags
// ************************************************************
module tmc_far_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic plug,
  input wire logic full,
  input wire logic moving,
  input wire logic tap,
  input wire logic near,
  input wire logic [1:0] level,
  output logic charger_pin,
  output logic battery_full_pin,
  output logic motion_pin,
  output logic nfc_access_pin,
  output logic nfc_release_pin,
  output logic batt_low,
  output logic batt_critical,
  output logic start_alert,
  output logic end_alert
);
  logic near_d;
  logic tap_d;
  logic [1:0] rel_cnt;
  // a full cell is only reported while charging
  always_comb begin
    charger_pin = plug;
    battery_full_pin = full && plug;
    motion_pin = moving;
    nfc_access_pin = tap;
    nfc_release_pin = rel_cnt != 2'h0;
    batt_low = level == 2'h1;
    batt_critical = level == 2'h2;
  end
  // alert events on entering and leaving the zone; release held 3 cycles for the synchroniser
  always_ff @(posedge sys_clk) begin
    near_d <= near;
    tap_d <= tap;
    start_alert <= near && !near_d && !rst;
    end_alert <= !near && near_d && !rst;
    if (rst) begin
      rel_cnt <= 2'h0;
    end else if (tap_d && !tap) begin
      rel_cnt <= 2'h3;
    end else if (rel_cnt != 2'h0) begin
      rel_cnt <= rel_cnt - 2'h1;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/test_tag_operating_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// self-checking bench for the mode controller
// ************************************************************
module test_tag_operating_mode_controller;
  logic sys_clk, rst, plug, full, moving, tap, near;
  logic [1:0] level;
  logic charger_pin, battery_full_pin, motion_pin, nfc_access_pin, nfc_release_pin;
  logic batt_low, batt_critical, start_alert, end_alert;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, report_mode, r;
  logic meas_request, led_on, buzzer, vibrator, scan_en, discovery_en;
  logic ranging_en, subghz_en, uwb_en, ble_nfc_en, log_en;
  logic [2:0] led_colour;
  int errors, checks;

  // short second and blink keep each timeout the bench writes within a few hundred cycles
  tmc_mode_ctrl #(.SEC_LEN(20), .BLINK_LEN(4), .TONE_LEN(2)) u_tmc_mode_ctrl (.*);
  tmc_far_model u_tmc_far_model (.*);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // each channel released at the edge it is taken; bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic st(input logic [4:0] e);
    rd(8'h10);
    chk("state", {27'h0, v[4:0]}, {27'h0, e});
  endtask

  task automatic t_reset;
    st(5'h01);
    chk("scan", scan_en, 0);
    chk("nfc radio", ble_nfc_en, 0);
    rd(8'h00);
    chk("ctrl", v, 32'h12);
    rd(8'h04);
    chk("motionless", v, 32'h258);
    rd(8'h08);
    chk("meas", v, 32'h3c);
    rd(8'h14);
    chk("unmapped resp", r, 2'h2);
    chk("unmapped data", v, 0);
    wr(8'h10, 32'hff);
    st(5'h01);
  endtask

  task automatic t_charge;
    plug <= 1'b1;
    cyc(6);
    st(5'h02);
    chk("charge colour", led_colour, tmc_pkg::LED_ORANGE);
    chk("charge scan", scan_en, 0);
    full <= 1'b1;
    cyc(6);
    chk("full colour", led_colour, tmc_pkg::LED_GREEN);
    st(5'h02);
    plug <= 1'b0;
    full <= 1'b0;
    cyc(6);
    st(5'h08);
    chk("blink", led_on, 0);
    chk("ranging", ranging_en, 1);
  endtask

  // the mode setting written by the configuring party
  task automatic t_modes;
    wr(8'h00, 32'h11);
    cyc(6);
    st(5'h04);
    wr(8'h00, 32'h12);
    cyc(6);
    st(5'h08);
    wr(8'h00, 32'h10);
    cyc(6);
    st(5'h01);
    wr(8'h00, 32'h12);
    plug <= 1'b1;
    cyc(6);
    plug <= 1'b0;
    cyc(6);
    st(5'h08);
  endtask

  task automatic t_options;
    wr(8'h00, 32'h16);
    plug <= 1'b1;
    cyc(6);
    chk("keep running", scan_en, 1);
    plug <= 1'b0;
    cyc(6);
    wr(8'h00, 32'h1a);
    cyc(3);
    chk("passive disc", discovery_en, 0);
    chk("passive scan", scan_en, 1);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'h12 | (i << 5));
      cyc(3);
      chk("report", report_mode, i);
      chk("log", log_en, i != 3);
    end
  endtask

  // alerts run with reporting off to show no network dependence
  task automatic t_alert;
    near <= 1'b1;
    cyc(5);
    chk("alert colour", led_colour, tmc_pkg::LED_RED);
    v = 0;
    repeat (12) @(posedge sys_clk) v |= {buzzer, vibrator};
    chk("alert pattern", v, 3);
    rd(8'h10);
    chk("alerting", v[6], 1);
    near <= 1'b0;
    cyc(5);
    rd(8'h10);
    chk("alert end", v[6], 0);
    wr(8'h0c, 32'h1);
    near <= 1'b1;
    cyc(45);
    rd(8'h10);
    chk("alert timeout", v[6], 0);
    near <= 1'b0;
    cyc(3);
  endtask

  task automatic t_nfc;
    tap <= 1'b1;
    cyc(6);
    st(5'h10);
    chk("subghz", subghz_en, 0);
    chk("nfc colour", led_colour, tmc_pkg::LED_BLUE);
    tap <= 1'b0;
    cyc(8);
    st(5'h08);
  endtask

  task automatic t_sleep;
    wr(8'h04, 32'h2);
    moving <= 1'b0;
    cyc(70);
    st(5'h04);
    moving <= 1'b1;
    cyc(6);
    st(5'h08);
  endtask

  task automatic t_batt;
    wr(8'h08, 32'h1);
    level <= 2'h1;
    cyc(25);
    rd(8'h10);
    chk("low", v[7], 1);
    st(5'h08);
    level <= 2'h2;
    cyc(25);
    st(5'h01);
    level <= 2'h0;
    cyc(25);
    st(5'h01);
    plug <= 1'b1;
    cyc(6);
    st(5'h02);
    plug <= 1'b0;
    cyc(6);
    st(5'h08);
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under two thousand cycles
  initial begin
    cyc(20000);
    errors++;
    complete_run();
  end

  initial begin
    {rst, moving, s_axi_wstrb} = {2'b11, 4'hf};
    {plug, full, tap, near, level} = 6'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    cyc(6);
    rst <= 1'b0;
    cyc(2);
    t_reset();
    t_charge();
    t_modes();
    t_options();
    t_alert();
    t_nfc();
    t_sleep();
    t_batt();
    complete_run();
  end
endmodule

bind tmc_mode_ctrl tmc_checker u_tmc_checker (.*);
`default_nettype wire
